/* hw/dpl_char_tx.sv */
// asynchronous character serializer stepped by transmit clock ticks
`timescale 1ns/1ns
`default_nettype none
module dpl_char_tx
	import dpl_pkg::*;
(
	input  wire logic       ref_clk, // system clock
	input  wire logic       rst_n,   // synchronous reset, low
	input  wire logic       ce,      // clock enable
	input  wire logic       tick,    // one bit time elapsed
	input  wire logic       start,   // load a character
	input  wire logic [7:0] data,    // character, lsb first
	input  wire logic [1:0] lenCode, // 0..3 means 5..8 bits
	input  wire logic       twoStop, // two stop bits
	input  wire logic [2:0] parity,  // parity mode
	output logic            txd,     // serial line, idle high
	output logic            busy     // character in flight
);
	dpl_txstate_t state;
	logic [7:0]   shift;
	logic [2:0]   bitCnt;
	logic         parBit;
	logic         stopCnt;
	logic [7:0]   masked;

	// drop bits above the character length before parity
	assign masked = data & (8'hff >> (2'h3 - lenCode));

	// serializer sequence
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state   <= TX_IDLE;
			shift   <= 8'h00;
			bitCnt  <= 3'h0;
			parBit  <= 1'b0;
			stopCnt <= 1'b0;
			txd     <= 1'b1;
		end
		else if (ce)
		begin
			case (state)
				TX_IDLE:
					if (start)
					begin
						shift <= masked;
						case (parity)
							PAR_ODD:  parBit <= ~^masked;
							PAR_EVEN: parBit <= ^masked;
							PAR_MARK: parBit <= 1'b1;
							default:  parBit <= 1'b0;
						endcase
						state <= TX_START;
					end
				TX_START:
					if (tick)
					begin
						txd    <= 1'b0; // low start bit launched on the clock
						bitCnt <= 3'({1'b0, lenCode} + 3'h4);
						state  <= TX_DATA;
					end
				TX_DATA:
					if (tick)
					begin
						txd   <= shift[0]; // lsb first
						shift <= {1'b0, shift[7:1]};
						if (bitCnt == 3'h0)
							state <= (parity == PAR_NONE) ? TX_STOP : TX_PAR;
						else
							bitCnt <= bitCnt - 3'h1;
						stopCnt <= twoStop;
					end
				TX_PAR:
					if (tick)
					begin
						txd   <= parBit; // one extra bit
						state <= TX_STOP;
					end
				default:
					if (tick)
					begin
						txd <= 1'b1; // stop bits high
						if (stopCnt)
							stopCnt <= 1'b0;
						else
							state <= TX_IDLE;
					end
			endcase
		end
	end

	assign busy = (state != TX_IDLE);
endmodule // dpl_char_tx
`default_nettype wire

/* hw/dpl_data_port.sv */
// data port: control leads, character framing and transmit clocking behind apb
//
// Contract
// - sync mode ignores terminal/set-ready leads
// - leads forced high, low or remote relay
// - remote relay only with channel-multiplex adaption; the code also relays slot 1 (rts/dcd) under transparent and leased
// - leased line: relay only on rts/dcd pair
// - lead defaults depend on gender
// - transparent 56k: rts into byte bit 8
// - incoming bit 8 drives local dcd
// - x21: control and indication leads only
// - branch variant: always dce, two leads
// - timing source accepts only lead settings
// - character length 5 to 8, default 8
// - one or two stop bits, default one
// - parity none/odd/even/mark/space adds bit
// - frame total 8 to 11, else rejected
// - transmit clock external, internal or slave
// - no internal clock with transparent/leased
// - external from pin, slave from stream
// - internal clock from generator, system-locked
// - dte: any source, slave default
// - clock state locked or pass-through
// - pass-through clock in signalling bit, 50 b/s
// - data launched and sampled on transmit clock
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module dpl_data_port
	import dpl_pkg::*;
#(
	parameter int          BRANCH_PORT = 0,        // 1 for the branch-port variant
	parameter int          BRG_HALF    = 16,       // generator half period in cycles
	parameter int          RATE_WIN    = 10000000, // rate window, one second of cycles
	parameter logic [23:0] NOMINAL_BPS = 24'd56000 // nominal data rate
)
(
	input  wire logic        ref_clk,        // 10 MHz system clock
	input  wire logic        rst_n,          // synchronous reset, low
	input  wire logic        ce,             // clock enable
	input  wire logic [7:0]  paddr,          // apb address
	input  wire logic        psel,           // apb select
	input  wire logic        penable,        // apb enable
	input  wire logic        pwrite,         // apb direction
	input  wire logic [31:0] pwdata,         // apb write data
	output logic      [31:0] prdata,         // apb read data
	output logic             pready,         // apb ready
	output logic             pslverr,        // apb error
	input  wire logic [3:0]  leadPinIn,      // lead pins from equipment
	output logic      [3:0]  leadPinOut,     // lead pins to equipment
	input  wire logic [3:0]  remoteLeadIn,   // far-end lead states
	output logic      [3:0]  netLeadOut,     // lead states to far end
	input  wire logic [6:0]  chanUserData,   // channel payload bits
	input  wire logic        chanTxStrobe,   // build a channel byte
	output logic      [7:0]  chanTxByte,     // outgoing channel byte
	input  wire logic [7:0]  chanRxByte,     // incoming channel byte
	input  wire logic        chanRxValid,    // incoming byte valid
	input  wire logic        extClkPin,      // external transmit clock pin
	input  wire logic        recoveredClkIn, // clock recovered from stream
	output logic             txClkOut,       // transmit clock to equipment
	output logic             txClkOe,        // transmit clock pin driven
	output logic             txData,         // async serial data
	output logic             muxSigBit       // multiplex signalling bit
);
	logic [CTRL_W-1:0] ctrl;
	logic [15:0]       lead;
	logic [5:0]        frame;
	logic              rejected;
	logic              rateDev;
	logic              wrEn;
	logic              rdEn;
	logic              mapped;
	logic              ctrlOk;
	logic              frameOk;
	logic              leadOk;
	logic              genderFlip;
	logic [1:0]        ra;
	logic [1:0]        clkSrc;
	logic [1:0]        wrRa;
	logic [1:0]        wrCs;
	logic [3:0]        frameBits;
	logic [3:0]        leadMeta;
	logic [3:0]        leadSync;
	logic              extMeta;
	logic              extSync;
	logic              extPrev;
	logic              recMeta;
	logic              recSync;
	logic              recPrev;
	logic [15:0]       brgCnt;
	logic              brgPhase;
	logic              brgTick;
	logic              txTick;
	logic              txClkLvl;
	logic              rxLeadBit;
	logic              txBusy;
	logic [23:0]       winCnt;
	logic [23:0]       tickCnt;
	logic [3:0]        used;
	logic [3:0]        e2eOk;

	assign ra     = ctrl[CTRL_RA_LO+:2];
	assign clkSrc = ctrl[CTRL_CS_LO+:2];
	assign wrRa   = pwdata[CTRL_RA_LO+:2];
	assign wrCs   = pwdata[CTRL_CS_LO+:2];

	// apb decode; the slave answers in the first access cycle
	assign pready = ce;
	assign wrEn   = psel && penable && pwrite && ce;
	assign rdEn   = psel && !penable && !pwrite && ce;
	always_comb
	begin
		if (paddr == ADDR_CTRL || paddr == ADDR_LEAD || paddr == ADDR_FRAME)
			mapped = 1'b1;
		else if (paddr == ADDR_STATUS)
			mapped = !pwrite;
		else if (paddr == ADDR_TXCHAR)
			mapped = pwrite;
		else
			mapped = 1'b0;
	end
	assign pslverr = psel && penable && !mapped;

	// validity of a control write
	always_comb
	begin
		ctrlOk = (wrRa != 2'h3) && (wrCs != 2'h3);
		if (wrCs == CLK_INT && wrRa != RA_HCM)
			ctrlOk = 1'b0;
		if (ctrl[CTRL_TSRC] && pwdata[CTRL_W-2:0] != ctrl[CTRL_W-2:0])
			ctrlOk = 1'b0;
	end

	// frame total: start, data, stop and optional parity
	assign frameBits = 4'h1 + MIN_DATA_BITS + {2'h0, pwdata[FRAME_LEN_LO+:2]} + {3'h0, pwdata[FRAME_STOP]}
		+ 4'h1 + {3'h0, pwdata[FRAME_PAR_LO+:3] != PAR_NONE};
	assign frameOk = (frameBits >= FRAME_MIN_BITS) && (frameBits <= FRAME_MAX_BITS)
		&& (pwdata[FRAME_PAR_LO+:3] <= PAR_SPACE) && !ctrl[CTRL_TSRC];

	// every lead field must be legal for the current adaption
	always_comb
	begin
		leadOk = 1'b1;
		for (int f = 0; f < 2 * LEAD_SLOTS; f++)
		begin
			if (pwdata[2*f+:2] == 2'h3)
				leadOk = 1'b0;
			if (pwdata[2*f+:2] == LEAD_E2E && ra != RA_HCM && (f % LEAD_SLOTS) != 1)
				leadOk = 1'b0;
		end
	end

	assign genderFlip = wrEn && paddr == ADDR_CTRL && ctrlOk && BRANCH_PORT == 0
		&& pwdata[CTRL_DTE] != ctrl[CTRL_DTE];

	// control register; the branch variant never leaves dce
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			ctrl <= CTRL_RESET; // sync, dce, slave clock
		else if (ce && wrEn && paddr == ADDR_CTRL && ctrlOk)
		begin
			ctrl <= pwdata[CTRL_W-1:0];
			if (BRANCH_PORT != 0)
				ctrl[CTRL_DTE] <= 1'b0;
		end
	end

	// lead settings stay writable even when cross-connected or a timing source
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			lead <= {LEAD_OUT_DCE_DEF, LEAD_IN_DEFAULT};
		else if (ce && genderFlip)
			lead <= {pwdata[CTRL_DTE] ? LEAD_OUT_DTE_DEF : LEAD_OUT_DCE_DEF, LEAD_IN_DEFAULT};
		else if (ce && wrEn && paddr == ADDR_LEAD && leadOk)
			lead <= pwdata[15:0];
	end

	// framing register; an illegal total keeps the old setting
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			frame <= FRAME_RESET; // 8 data, 1 stop, no parity
		else if (ce && wrEn && paddr == ADDR_FRAME && frameOk)
			frame <= pwdata[5:0];
	end

	// rejected write flag, cleared by the next accepted configuration write
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			rejected <= 1'b0;
		else if (ce && wrEn && paddr == ADDR_CTRL)
			rejected <= !ctrlOk;
		else if (ce && wrEn && paddr == ADDR_LEAD)
			rejected <= !leadOk;
		else if (ce && wrEn && paddr == ADDR_FRAME)
			rejected <= !frameOk;
	end

	// read data registered in the setup cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (rdEn)
		begin
			if (paddr == ADDR_CTRL)
				prdata <= {23'h0, ctrl};
			else if (paddr == ADDR_LEAD)
				prdata <= {16'h0, lead};
			else if (paddr == ADDR_FRAME)
				prdata <= {26'h0, frame};
			else if (paddr == ADDR_STATUS)
				prdata <= {20'h0, txClkLvl, rateDev, rejected, txBusy, netLeadOut, leadPinOut};
			else
				prdata <= 32'h0000_0000;
		end
	end

	// two-flop synchronisers for everything arriving on pins
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			leadMeta <= 4'h0;
			leadSync <= 4'h0;
			extMeta  <= 1'b0;
			extSync  <= 1'b0;
			extPrev  <= 1'b0;
			recMeta  <= 1'b0;
			recSync  <= 1'b0;
			recPrev  <= 1'b0;
		end
		else if (ce)
		begin
			leadMeta <= leadPinIn;
			leadSync <= leadMeta;
			extMeta  <= extClkPin;
			extSync  <= extMeta;
			extPrev  <= extSync;
			recMeta  <= recoveredClkIn;
			recSync  <= recMeta;
			recPrev  <= recSync;
		end
	end

	// baud rate generator counts system clock, so it is locked to node timing
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			brgCnt   <= 16'h0000;
			brgPhase <= 1'b0;
		end
		else if (ce)
		begin
			if (brgCnt == 16'(BRG_HALF - 1))
			begin
				brgCnt   <= 16'h0000;
				brgPhase <= !brgPhase;
			end
			else
				brgCnt <= brgCnt + 16'h0001;
		end
	end
	assign brgTick = (brgCnt == 16'(BRG_HALF - 1)) && !brgPhase;

	// transmit clock source select
	always_comb
	begin
		case (clkSrc)
			CLK_EXT:
			begin
				txTick   = extSync && !extPrev; // pin from equipment
				txClkLvl = extSync;
			end
			CLK_INT:
			begin
				txTick   = brgTick;
				txClkLvl = brgPhase;
			end
			default:
			begin
				txTick   = recSync && !recPrev; // timing from the stream
				txClkLvl = recSync;
			end
		endcase
	end
	assign txClkOut = (clkSrc == CLK_EXT) ? 1'b0 : txClkLvl;
	assign txClkOe  = (clkSrc != CLK_EXT);

	// lead mapping per slot: slot 1 is the rts/dcd pair in both genders
	generate
		for (genvar i = 0; i < LEAD_SLOTS; i++)
		begin : g_slot
			logic [1:0] inCode;
			logic [1:0] outCode;
			logic       remote;
			assign inCode  = lead[2*i+:2];
			assign outCode = lead[LEAD_OUT_LO+2*i+:2];
			assign used[i] = !(i == 0 && !ctrl[CTRL_ASYNC])
				&& !(ctrl[CTRL_X21] && i != 1)
				&& !(BRANCH_PORT != 0 && i > 1);
			assign e2eOk[i] = (ra == RA_HCM) || (i == 1);
			assign remote = (i == 1 && ra == RA_TRANSP) ? rxLeadBit : remoteLeadIn[i];
			assign leadPinOut[i] = used[i] && (outCode == LEAD_HIGH
				|| (outCode == LEAD_E2E && e2eOk[i] && remote));
			assign netLeadOut[i] = used[i] && (inCode == LEAD_HIGH
				|| (inCode == LEAD_E2E && e2eOk[i] && leadSync[i]));
		end
	endgenerate

	// channel byte build and relayed lead extraction
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			chanTxByte <= 8'h00;
			rxLeadBit  <= 1'b0;
		end
		else if (ce)
		begin
			if (chanTxStrobe)
				chanTxByte <= {(ra == RA_TRANSP && lead[3:2] == LEAD_E2E) ? netLeadOut[1] : 1'b0,
					chanUserData};
			if (chanRxValid)
				rxLeadBit <= chanRxByte[CHAN_LEAD_BIT];
		end
	end

	// rate monitor for pass-through clocks; counts bits per window
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			winCnt  <= 24'h000000;
			tickCnt <= 24'h000000;
			rateDev <= 1'b0;
		end
		else if (ce && !ctrl[CTRL_INDEP])
		begin
			winCnt  <= 24'h000000;
			tickCnt <= 24'h000000;
			rateDev <= 1'b0;
		end
		else if (ce)
		begin
			if (winCnt == 24'(RATE_WIN - 1))
			begin
				winCnt  <= 24'h000000;
				tickCnt <= 24'h000000;
				rateDev <= (tickCnt > NOMINAL_BPS + RATE_TOL_BPS)
					|| (tickCnt + RATE_TOL_BPS < NOMINAL_BPS);
			end
			else
			begin
				winCnt  <= winCnt + 24'h000001;
				tickCnt <= tickCnt + {23'h0, txTick};
			end
		end
	end

	// clock phase rides the signalling bit only in pass-through state
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			muxSigBit <= 1'b0;
		else if (ce)
			muxSigBit <= ctrl[CTRL_INDEP] && txClkLvl;
	end

	// async serializer; a write while busy is dropped
	dpl_char_tx u_tx (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.tick    (txTick),
		.start   (wrEn && paddr == ADDR_TXCHAR && ctrl[CTRL_ASYNC] && !txBusy),
		.data    (pwdata[7:0]),
		.lenCode (frame[FRAME_LEN_LO+:2]),
		.twoStop (frame[FRAME_STOP]),
		.parity  (frame[FRAME_PAR_LO+:3]),
		.txd     (txData),
		.busy    (txBusy)
	);

	// checks
	a_sync_leads_dead: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		!ctrl[CTRL_ASYNC] |-> !leadPinOut[0] && !netLeadOut[0]) else $error("sync mode drives dtr/dsr");
	a_forced_high_out: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		lead[11:10] == LEAD_HIGH && used[1] |-> leadPinOut[1]) else $error("forced high lead low");
	a_relay_needs_hcm: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		ra != RA_HCM && lead[LEAD_OUT_LO+:2] == LEAD_E2E |-> !leadPinOut[0]) else $error("relay without hcm");
	a_leased_pair_only: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		wrEn && paddr == ADDR_LEAD && ra == RA_LDL && pwdata[5:4] == LEAD_E2E |=> $stable(lead))
		else $error("leased relay off pair accepted");
	a_gender_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		genderFlip |=> lead == {ctrl[CTRL_DTE] ? LEAD_OUT_DTE_DEF : LEAD_OUT_DCE_DEF, LEAD_IN_DEFAULT})
		else $error("gender defaults not loaded");
	a_rts_in_bit8: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		chanTxStrobe && ra == RA_TRANSP && lead[3:2] == LEAD_E2E |=> chanTxByte[7] == $past(netLeadOut[1]))
		else $error("rts not in bit 8");
	a_bit8_to_dcd: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		ra == RA_TRANSP && lead[11:10] == LEAD_E2E && used[1] |-> leadPinOut[1] == rxLeadBit)
		else $error("bit 8 not on dcd");
	a_x21_unused: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		ctrl[CTRL_X21] |-> leadPinOut[3:2] == 2'h0 && netLeadOut[0] == 1'b0) else $error("x21 spare lead active");
	a_tsrc_frame_lock: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		ctrl[CTRL_TSRC] && wrEn && paddr == ADDR_FRAME |=> $stable(frame)) else $error("timing source framed");
	a_frame_window: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		wrEn && paddr == ADDR_FRAME && (frameBits < FRAME_MIN_BITS || frameBits > FRAME_MAX_BITS)
		|=> $stable(frame) && rejected) else $error("bad frame total accepted");
	a_internal_hcm: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		clkSrc == CLK_INT |-> ra == RA_HCM) else $error("internal clock without hcm");
	a_sigbit_locked: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
		!ctrl[CTRL_INDEP] [*2] |-> !muxSigBit) else $error("signalling bit used while locked");
	c_async_char: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(txBusy));
	c_relay_dcd: cover property (@(posedge ref_clk) disable iff (!rst_n) ra == RA_TRANSP && $rose(leadPinOut[1]));
	c_rate_dev: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(rateDev));
endmodule // dpl_data_port
`default_nettype wire

/* hw/dpl_pkg.sv */
// shared constants and types for the data port lead, framing and clocking block
package dpl_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_LEAD   = 8'h04;
	localparam logic [7:0] ADDR_FRAME  = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_TXCHAR = 8'h10;
	// control register fields
	localparam int CTRL_ASYNC  = 0;
	localparam int CTRL_DTE    = 1;
	localparam int CTRL_RA_LO  = 2;
	localparam int CTRL_CS_LO  = 4;
	localparam int CTRL_INDEP  = 6;
	localparam int CTRL_X21    = 7;
	localparam int CTRL_TSRC   = 8;
	localparam int CTRL_W      = 9;
	localparam logic [8:0] CTRL_RESET = 9'h020;
	// lead register: four input slots low, four output slots high, two bits each
	localparam int LEAD_SLOTS = 4;
	localparam int LEAD_OUT_LO = 8;
	localparam logic [7:0] LEAD_IN_DEFAULT  = 8'haa;
	localparam logic [7:0] LEAD_OUT_DCE_DEF = 8'h29;
	localparam logic [7:0] LEAD_OUT_DTE_DEF = 8'h69;
	// frame register fields
	localparam int FRAME_LEN_LO = 0;
	localparam int FRAME_STOP   = 2;
	localparam int FRAME_PAR_LO = 3;
	localparam logic [5:0] FRAME_RESET = 6'h03;
	localparam logic [3:0] FRAME_MIN_BITS = 4'h8;
	localparam logic [3:0] FRAME_MAX_BITS = 4'hb;
	localparam logic [3:0] MIN_DATA_BITS  = 4'h5;
	// status register fields
	localparam int ST_BUSY   = 8;
	localparam int ST_REJECT = 9;
	localparam int ST_RATE   = 10;
	localparam int ST_TXCLK  = 11;
	// channel byte position carrying the relayed lead
	localparam int CHAN_LEAD_BIT = 7;
	// rate tolerance in b/s for pass-through clocks
	localparam logic [23:0] RATE_TOL_BPS = 24'h000032;
	typedef enum logic [1:0] {LEAD_LOW, LEAD_HIGH, LEAD_E2E} dpl_lead_t;
	typedef enum logic [1:0] {RA_HCM, RA_TRANSP, RA_LDL} dpl_rate_t;
	typedef enum logic [1:0] {CLK_EXT, CLK_INT, CLK_SLAVE} dpl_clksrc_t;
	typedef enum logic [2:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE} dpl_parity_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} dpl_txstate_t;
endpackage

/* test/dpl_data_port_tb.sv */
// self-checking bench for the data port lead, framing and clocking block
`timescale 1ns/1ns
`default_nettype none
module dpl_data_port_tb
	import dpl_pkg::*;
;
	logic        ref_clk, rst_n, psel, penable, pwrite, chanTxStrobe, chanRxValid, recClk, clkOn, ce, hold;
	logic        pready, pslverr, er, extClk, txClkOut, txClkOe, txData, muxSigBit, ok;
	logic [7:0]  paddr, chanRxByte, chanTxByte, dv;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  leadPinIn, remoteLeadIn, leadPinOut, netLeadOut;
	logic [6:0]  chanUserData;
	logic [5:0]  fv, v, fr;
	logic [10:0] exq[$];
	int          n_mismatch, comparisons, k;
	int unsigned seed = 38318;

	dpl_data_port #(.BRG_HALF(4), .RATE_WIN(1000), .NOMINAL_BPS(24'd56)) uut (
		.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.leadPinIn(leadPinIn), .leadPinOut(leadPinOut), .remoteLeadIn(remoteLeadIn), .netLeadOut(netLeadOut),
		.chanUserData(chanUserData), .chanTxStrobe(chanTxStrobe), .chanTxByte(chanTxByte),
		.chanRxByte(chanRxByte), .chanRxValid(chanRxValid), .extClkPin(extClk), .recoveredClkIn(recClk),
		.txClkOut(txClkOut), .txClkOe(txClkOe), .txData(txData), .muxSigBit(muxSigBit));
	dpl_equip_model #(.BIT(8)) eq (.ref_clk(ref_clk), .txLine(txData), .clkOn(clkOn), .extClk(extClk));

	// 10 MHz system clock
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// recovered network clock, free running
	always @(posedge ref_clk)
		recClk <= ~recClk;
	// watchdog well beyond the expected few thousand cycles
	initial
	begin
		#2000000;
		n_mismatch++;
		test_done;
	end

	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected line bits: start low, data, parity, then high to the end
	function automatic logic [10:0] frame(input logic [7:0] d, input int len, input int par);
		logic [10:0] f;
		logic [7:0]  m;
		m = d & 8'((1 << len) - 1);
		f = 11'h7fe;
		for (int i = 0; i < len; i++)
			f[1 + i] = m[i];
		if (par != 0)
			f[1 + len] = (par == 1) ? ~^m : (par == 2) ? ^m : (par == 3);
		return f;
	endfunction
	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge ref_clk);
			if (pready === 1'b1)
				break;
		end
		// a slave that never answers counts against the run
		if (k == 20)
			n_mismatch++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	// main sequence
	initial
	begin
		{psel, penable, pwrite, chanTxStrobe, chanRxValid, recClk, clkOn} = 7'h00;
		{paddr, pwdata, chanRxByte, chanUserData} = 55'h0;
		{leadPinIn, remoteLeadIn} = 8'h00;
		ce = 1'b1;
		rst_n = 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		rdchk(ADDR_CTRL, 32'h00000020, "ctrl");
		rdchk(ADDR_LEAD, 32'h000029aa, "lead");
		rdchk(ADDR_FRAME, 32'h00000003, "frame");
		chk("pin0 sync", 32'h0, {31'h0, leadPinOut[0]});
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		// async, internal generator, channel multiplex: relay on defaults
		wr(ADDR_CTRL, 32'h00000011);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge ref_clk);
			remoteLeadIn <= 4'(rnd());
			leadPinIn <= 4'(rnd());
			repeat (4) @(posedge ref_clk);
			chk("pins out", {28'h0, 1'b0, remoteLeadIn[2:1], 1'b1}, {28'h0, leadPinOut});
			chk("net out", {28'h0, leadPinIn}, {28'h0, netLeadOut});
		end
		// every parity mode with eight data bits, then two-stop five-bit characters of nine and eight bits
		for (int i = 0; i < 7; i++)
		begin
			fv = (i < 5) ? {3'(i), 3'h3} : (i == 5) ? 6'h0c : 6'h04;
			wr(ADDR_FRAME, {26'h0, fv});
			dv = 8'(rnd());
			wr(ADDR_TXCHAR, {24'h0, dv});
			exq.push_back(frame(dv, 5 + fv[1:0], fv[5:3]));
			for (k = 0; k < 400 && eq.rxq.size() == 0; k++)
				@(posedge ref_clk);
			chk("char", {21'h0, exq.pop_front()}, {21'h0, eq.rxq.pop_front()});
			repeat (30) @(posedge ref_clk);
		end
		// random framing words against the total length window
		fr = 6'h04;
		for (int i = 0; i < 16; i++)
		begin
			v = (i == 0) ? 6'h00 : (i == 1) ? 6'h1f : 6'(rnd());
			ok = (v[5:3] <= 3'h4) && ((7 + v[1:0] + v[2] + (v[5:3] != 0)) inside {[8:11]});
			if (ok)
				fr = v;
			wr(ADDR_FRAME, {26'h0, v});
			rdchk(ADDR_FRAME, {26'h0, fr}, "frame");
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk("reject", {31'h0, !ok}, {31'h0, rd[ST_REJECT]});
		end
		// each transmit clock source drives the pin or not
		clkOn <= 1'b1;
		for (int s = 0; s < 3; s++)
		begin
			wr(ADDR_CTRL, 32'h1 | (s << 4));
			repeat (4) @(posedge ref_clk);
			chk("clk oe", {31'h0, s != 0}, {31'h0, txClkOe});
		end
		// a low enable freezes the synchronised stream clock
		@(posedge ref_clk);
		ce <= 1'b0;
		repeat (2) @(negedge ref_clk);
		hold = txClkOut;
		repeat (4) @(negedge ref_clk);
		chk("ce freeze", {31'h0, hold}, {31'h0, txClkOut});
		@(posedge ref_clk);
		ce <= 1'b1;
		// pass-through clock rides the signalling bit and is rate checked
		wr(ADDR_CTRL, 32'h00000061);
		repeat (2) @(negedge ref_clk);
		hold = muxSigBit;
		@(negedge ref_clk);
		chk("sig bit", 32'h1, {31'h0, hold ^ muxSigBit});
		repeat (1100) @(posedge ref_clk);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("rate dev", 32'h1, {31'h0, rd[ST_RATE]});
		wr(ADDR_CTRL, 32'h00000021);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("rate clr", 32'h0, {31'h0, rd[ST_RATE] | muxSigBit});
		wr(ADDR_CTRL, 32'h00000023);
		rdchk(ADDR_LEAD, 32'h000069aa, "lead dte");
		// transparent sync dce: internal clock and wide relay refused
		wr(ADDR_CTRL, 32'h00000024);
		wr(ADDR_CTRL, 32'h00000014);
		rdchk(ADDR_CTRL, 32'h00000024, "ctrl kept");
		wr(ADDR_LEAD, 32'h000029aa);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("tx idle", 32'h0, {31'h0, rd[ST_BUSY]});
		chk("lead reject", 32'h1, {31'h0, rd[ST_REJECT]});
		wr(ADDR_LEAD, 32'h00000959);
		for (int b = 1; b >= 0; b--)
		begin
			@(posedge ref_clk);
			leadPinIn <= {2'h0, 1'(b), 1'b0};
			chanUserData <= 7'(rnd());
			repeat (4) @(posedge ref_clk);
			chanTxStrobe <= 1'b1;
			@(posedge ref_clk);
			chanTxStrobe <= 1'b0;
			@(negedge ref_clk);
			chk("chan byte", {24'h0, 1'(b), chanUserData}, {24'h0, chanTxByte});
			@(posedge ref_clk);
			chanRxByte <= {1'(b), 7'(rnd())};
			chanRxValid <= 1'b1;
			@(posedge ref_clk);
			chanRxValid <= 1'b0;
			repeat (2) @(posedge ref_clk);
			chk("dcd relay", b, {31'h0, leadPinOut[1]});
		end
		// leased line with x21: only the pair relays, spare leads idle
		wr(ADDR_CTRL, 32'h00000088);
		wr(ADDR_LEAD, 32'h000029aa);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("leased reject", 32'h1, {31'h0, rd[ST_REJECT]});
		wr(ADDR_LEAD, 32'h00004155);
		repeat (2) @(posedge ref_clk);
		chk("x21 pins", 32'h0, {28'h0, leadPinOut});
		chk("x21 net", 32'h2, {28'h0, netLeadOut});
		// a timing source takes lead settings but no framing
		wr(ADDR_CTRL, 32'h00000188);
		wr(ADDR_FRAME, {26'h0, fr ^ 6'h04});
		rdchk(ADDR_FRAME, {26'h0, fr}, "tsrc frame");
		test_done;
	end
endmodule // dpl_data_port_tb
`default_nettype wire

/* test/dpl_equip_model.sv */
// attached equipment: external transmit clock source and async character receiver
`timescale 1ns/1ns
`default_nettype none
module dpl_equip_model #(
	parameter int BIT = 8 // system cycles per bit time
)
(
	input  wire logic ref_clk, // system clock
	input  wire logic txLine,  // serial data from the port
	input  wire logic clkOn,   // run the external clock
	output logic      extClk   // transmit clock toward the port
);
	logic [10:0] rxq[$];
	logic [10:0] sh;
	// clock stands low when not asked for, so no stray ticks
	always @(posedge ref_clk)
		extClk <= clkOn ? ~extClk : 1'b0;
	// sample mid-bit from the falling start edge, lsb first
	initial forever
	begin
		@(negedge txLine);
		repeat (BIT / 2) @(posedge ref_clk);
		for (int i = 0; i < 11; i++)
		begin
			sh[i] = txLine;
			repeat (BIT) @(posedge ref_clk);
		end
		rxq.push_back(sh);
	end
endmodule // dpl_equip_model
`default_nettype wire
